// ===== core/fbos_defines.vh
`ifndef FBOS_DEFINES_VH
`define FBOS_DEFINES_VH
// Bank geometry
`define FBOS_NUM_BANKS     16
`define FBOS_BANK_W        4
`define FBOS_ADDR_W        23
`define FBOS_BANK_LSB      19
// Output state codes, one-hot
`define FBOS_ST_W          4
`define FBOS_ST_ARRAY      4'h1
`define FBOS_ST_STATUS     4'h2
`define FBOS_ST_SIG        4'h4
`define FBOS_ST_CFI        4'h8
`define FBOS_ST_RESET      4'h1
// Command codes
`define FBOS_CMD_READ_ARRAY  8'hFF
`define FBOS_CMD_PROG_10     8'h10
`define FBOS_CMD_PROG_40     8'h40
`define FBOS_CMD_BUF_PROG    8'hE8
`define FBOS_CMD_BLK_ERASE   8'h20
`define FBOS_CMD_BFP_SETUP   8'h80
`define FBOS_CMD_BLANK_SETUP 8'hBC
`define FBOS_CMD_CONFIRM     8'hD0
`define FBOS_CMD_BLANK_CONF  8'hCB
`define FBOS_CMD_SUSPEND     8'hB0
`define FBOS_CMD_READ_STATUS 8'h70
`define FBOS_CMD_CLR_STATUS  8'h50
`define FBOS_CMD_READ_SIG    8'h90
`define FBOS_CMD_READ_CFI    8'h98
// Read data source select
`define FBOS_SRC_W         2
`define FBOS_SRC_ARRAY     2'h0
`define FBOS_SRC_STATUS    2'h1
`define FBOS_SRC_SIG       2'h2
`define FBOS_SRC_CFI       2'h3
`endif

// ===== core/fbos_bank_state.v
`timescale 1ns/1ps
`include "fbos_defines.vh"
module fbos_bank_state
(
  // Clock and reset
  input  wire                   core_clk_i,
  input  wire                   rst_n_i,
  // Update from command decode
  input  wire                   load_i,
  input  wire [`FBOS_ST_W-1:0]  state_i,
  // Current output state
  output wire [`FBOS_ST_W-1:0]  state_o
);
  reg [`FBOS_ST_W-1:0] state_reg;
  reg [`FBOS_ST_W-1:0] state_next;

  always @*
  begin
    state_next = state_reg;
    if (load_i)
    begin
      state_next = state_i; // RQ3
    end
  end

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= `FBOS_ST_RESET; // RQ5
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg;
endmodule

// ===== core/fbos_output_select.v
`timescale 1ns/1ps
`include "fbos_defines.vh"
// Functional notes
// RQ1: A bank's output state applies only to reads addressed within that bank.
// RQ2: Four output states: array, status, signature, query; last command selects.
// RQ3: Each bank keeps its own state until a command reaches that bank.
// RQ4: Command sequencing never looks at any bank's output state.
// RQ5: After power-up every bank reads array contents.
// RQ6: Array read to a busy bank gives undefined data; host must not rely.
// RQ7: Host writes both cycles of a two-cycle command to one bank.
// RQ8: While program/erase controller is active, two-cycle commands are ignored.
// RQ9: Program, buffer, erase, factory and blank-check setup select status output.
// RQ10: Status read selects status; clear, confirm, suspend leave state unchanged.
module fbos_output_select
(
  // Clock and reset
  input  wire                     core_clk_i,
  input  wire                     rst_n_i,
  // Command write from the flash bus, same clock
  input  wire                     cmd_we_i,
  input  wire [`FBOS_ADDR_W-1:0]  cmd_addr_i,
  input  wire [7:0]               cmd_data_i,
  // Program/erase controller status
  input  wire                     pec_active_i,
  input  wire                     illegal_state_i,
  // Read address
  input  wire [`FBOS_ADDR_W-1:0]  rd_addr_i,
  // Read source select, state of the bank being read, and ignore flag
  output reg  [`FBOS_SRC_W-1:0]   rd_src_o,
  output wire [`FBOS_ST_W-1:0]    rd_state_o,
  output reg                      cmd_ignored_o
);
  // Bank field of an address, used for both write and read paths
  function [`FBOS_BANK_W-1:0] bank_of;
    input [`FBOS_ADDR_W-1:0] a;
    begin
      bank_of = a[`FBOS_ADDR_W-1:`FBOS_BANK_LSB];
    end
  endfunction

  // Setup cycle of a two-cycle program, erase or blank-check sequence
  function is_setup;
    input [7:0] c;
    begin
      case (c)
        `FBOS_CMD_PROG_10,
        `FBOS_CMD_PROG_40,
        `FBOS_CMD_BUF_PROG,
        `FBOS_CMD_BLK_ERASE,
        `FBOS_CMD_BFP_SETUP,
        `FBOS_CMD_BLANK_SETUP:
        begin
          is_setup = 1'b1;
        end
        default:
        begin
          is_setup = 1'b0;
        end
      endcase
    end
  endfunction

  // Second cycle of a pair
  function is_confirm;
    input [7:0] c;
    begin
      case (c)
        `FBOS_CMD_CONFIRM,
        `FBOS_CMD_BLANK_CONF:
        begin
          is_confirm = 1'b1;
        end
        default:
        begin
          is_confirm = 1'b0;
        end
      endcase
    end
  endfunction

  // Shift keeps the strobe vector at bank count width, no integer compare
  function [`FBOS_NUM_BANKS-1:0] bank_onehot;
    input [`FBOS_BANK_W-1:0] b;
    begin
      bank_onehot = {{(`FBOS_NUM_BANKS-1){1'b0}}, 1'b1} << b;
    end
  endfunction

  reg                    second_pending_reg;
  reg                    second_pending_next;
  reg                    load_en;
  reg [`FBOS_ST_W-1:0]   new_state;
  reg                    ignored_next;
  wire [`FBOS_BANK_W-1:0] wr_bank;
  wire [`FBOS_BANK_W-1:0] rd_bank;
  wire [`FBOS_ST_W*`FBOS_NUM_BANKS-1:0] states_flat;
  wire [`FBOS_NUM_BANKS-1:0]            bank_load;

  assign wr_bank = bank_of(cmd_addr_i);
  assign rd_bank = bank_of(rd_addr_i);

  // A load strobe reaches only the addressed bank
  assign bank_load = load_en ? bank_onehot(wr_bank)
                             : {`FBOS_NUM_BANKS{1'b0}}; // RQ3

  // Decode of the written command; no bank state is read here
  always @*
  begin
    load_en = 1'b0;
    new_state = `FBOS_ST_ARRAY;
    ignored_next = 1'b0;
    second_pending_next = second_pending_reg;
    if (cmd_we_i)
    begin
      second_pending_next = 1'b0;
      if (pec_active_i && (is_setup(cmd_data_i) ||
          (second_pending_reg && is_confirm(cmd_data_i))))
      begin
        // Both cycles dropped; the dropped setup arms a confirm so the pair's confirm is dropped too
        ignored_next = 1'b1; // RQ8
        second_pending_next = is_setup(cmd_data_i); // RQ8
      end
      else if (illegal_state_i)
      begin
        load_en = 1'b0;
      end
      else
      begin
        case (cmd_data_i) // RQ4
          `FBOS_CMD_READ_ARRAY:
          begin
            // Data from a busy bank is undefined; array still selected
            load_en = 1'b1; // RQ6
            new_state = `FBOS_ST_ARRAY; // RQ2
          end
          `FBOS_CMD_READ_STATUS:
          begin
            load_en = 1'b1; // RQ10
            new_state = `FBOS_ST_STATUS;
          end
          `FBOS_CMD_READ_SIG:
          begin
            load_en = 1'b1; // RQ2
            new_state = `FBOS_ST_SIG;
          end
          `FBOS_CMD_READ_CFI:
          begin
            load_en = 1'b1; // RQ2
            new_state = `FBOS_ST_CFI;
          end
          `FBOS_CMD_PROG_10,
          `FBOS_CMD_PROG_40,
          `FBOS_CMD_BUF_PROG,
          `FBOS_CMD_BLK_ERASE,
          `FBOS_CMD_BFP_SETUP,
          `FBOS_CMD_BLANK_SETUP:
          begin
            load_en = 1'b1; // RQ9
            new_state = `FBOS_ST_STATUS; // RQ9
          end
          `FBOS_CMD_CLR_STATUS,
          `FBOS_CMD_CONFIRM,
          `FBOS_CMD_BLANK_CONF,
          `FBOS_CMD_SUSPEND:
          begin
            // Clear, confirm, suspend keep the bank's mode
            load_en = 1'b0; // RQ10
          end
          default:
          begin
            // Lock and configuration codes are decoded elsewhere
            load_en = 1'b0;
          end
        endcase
      end
    end
  end

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      second_pending_reg <= 1'b0;
      cmd_ignored_o <= 1'b0;
    end
    else
    begin
      second_pending_reg <= second_pending_next;
      cmd_ignored_o <= ignored_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `FBOS_NUM_BANKS; g = g + 1)
    begin : g_bank
      fbos_bank_state fbos_bank_state_inst
      (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .load_i     (bank_load[g]), // RQ3
        .state_i    (new_state),
        .state_o    (states_flat[g*`FBOS_ST_W +: `FBOS_ST_W])
      );
    end
  endgenerate

  // Only the bank being read contributes its mode
  assign rd_state_o = states_flat[rd_bank*`FBOS_ST_W +: `FBOS_ST_W]; // RQ1

  always @*
  begin
    case (rd_state_o)
      `FBOS_ST_STATUS:
      begin
        rd_src_o = `FBOS_SRC_STATUS;
      end
      `FBOS_ST_SIG:
      begin
        rd_src_o = `FBOS_SRC_SIG;
      end
      `FBOS_ST_CFI:
      begin
        rd_src_o = `FBOS_SRC_CFI;
      end
      default:
      begin
        rd_src_o = `FBOS_SRC_ARRAY;
      end
    endcase
  end
endmodule

// ===== verif/fbos_output_select_props.sv
`timescale 1ns/1ps
module fbos_output_select_props
(
  input wire        core_clk_i,
  input wire        rst_n_i,
  input wire        cmd_we_i,
  input wire [22:0] cmd_addr_i,
  input wire [7:0]  cmd_data_i,
  input wire        pec_active_i,
  input wire        illegal_state_i,
  input wire [22:0] rd_addr_i,
  input wire [1:0]  rd_src_o,
  input wire [3:0]  rd_state_o,
  input wire        cmd_ignored_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Write that targets the bank being read
  wire hit = cmd_we_i && !illegal_state_i
    && cmd_addr_i[22:19] == rd_addr_i[22:19];
  wire su = cmd_data_i inside {8'h10, 8'h40, 8'hE8, 8'h20, 8'h80, 8'hBC};
  wire kp = cmd_data_i inside {8'h50, 8'hD0, 8'hCB, 8'hB0};
  chk_src_state: assert property (rd_state_o == 4'h1 << rd_src_o)
    else $error("source and state disagree");
  chk_reset_array: assert property (disable iff (1'b0)
    !rst_n_i |=> rd_src_o == 2'h0 && !cmd_ignored_o) else $error("no reset");
  chk_status_load: assert property (hit && cmd_data_i == 8'h70
    ##1 $stable(rd_addr_i) |-> rd_state_o == 4'h2) else $error("no status");
  chk_setup_status: assert property (hit && su && !pec_active_i
    ##1 $stable(rd_addr_i) |-> rd_state_o == 4'h2) else $error("no setup");
  chk_read_modes: assert property (hit && cmd_data_i[4] && cmd_data_i
    inside {8'hFF, 8'h90, 8'h98} ##1 $stable(rd_addr_i) |-> rd_state_o ==
    ($past(cmd_data_i[0]) ? 4'h1 : $past(cmd_data_i[3]) ? 4'h8 : 4'h4))
    else $error("wrong read mode");
  chk_busy_ignore: assert property (cmd_we_i && su && pec_active_i
    && !illegal_state_i |=> cmd_ignored_o) else $error("setup not ignored");
  chk_ignore_cause: assert property (cmd_ignored_o
    |-> $past(cmd_we_i) && $past(pec_active_i)) else $error("stray ignore");
  chk_hold_state: assert property ((!hit || kp || su && pec_active_i)
    ##1 $stable(rd_addr_i) |-> $stable(rd_state_o)) else $error("state moved");
endmodule
bind fbos_output_select fbos_output_select_props fbos_output_select_props_inst
  (.core_clk_i, .rst_n_i, .cmd_we_i, .cmd_addr_i, .cmd_data_i, .pec_active_i,
  .illegal_state_i, .rd_addr_i, .rd_src_o, .rd_state_o, .cmd_ignored_o);

// ===== verif/fbos_host_model.sv
`timescale 1ns/1ps
module fbos_host_model
(
  input  wire        core_clk_i,
  output reg         cmd_we_o = 1'b0,
  output reg  [22:0] cmd_addr_o = 23'h0,
  output reg  [7:0]  cmd_data_o = 8'h0
);
  // Callers keep both cycles of a pair in one bank
  task wr(input [3:0] bank, input [7:0] code);
  begin
    @(posedge core_clk_i) #1;
    cmd_we_o = 1'b1;
    cmd_addr_o = {bank, 19'h2A5C3};
    cmd_data_o = code;
    @(posedge core_clk_i) #1;
    cmd_we_o = 1'b0;
    // Idle bus shows no stale value
    cmd_addr_o = ~cmd_addr_o;
    cmd_data_o = ~cmd_data_o;
  end
  endtask
endmodule

// ===== verif/flash_bank_output_state_select_test.sv
`timescale 1ns/1ps
module flash_bank_output_state_select_test;
  reg         core_clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         pec_active_i = 1'b0;
  reg         illegal_state_i = 1'b0;
  reg  [22:0] rd_addr_i = 23'h0;
  wire        cmd_we_i;
  wire [22:0] cmd_addr_i;
  wire [7:0]  cmd_data_i;
  wire [1:0]  rd_src_o;
  wire [3:0]  rd_state_o;
  wire        cmd_ignored_o;
  integer     mismatches = 0;
  integer     total_checks = 0;
  initial
  begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  fbos_output_select fbos_output_select_inst (.core_clk_i, .rst_n_i,
    .cmd_we_i, .cmd_addr_i, .cmd_data_i, .pec_active_i, .illegal_state_i,
    .rd_addr_i, .rd_src_o, .rd_state_o, .cmd_ignored_o);
  fbos_host_model fbos_host_model_inst (.core_clk_i, .cmd_we_o(cmd_we_i),
    .cmd_addr_o(cmd_addr_i), .cmd_data_o(cmd_data_i));
  task cmp(input [7:0] got, input [7:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  // Read address follows each write so the checker sees the hit
  task wr(input [3:0] b, input [7:0] c);
  begin
    @(posedge core_clk_i) #1;
    rd_addr_i = {b, 19'h0F0F};
    fbos_host_model_inst.wr(b, c);
  end
  endtask
  task see(input [3:0] b, input [1:0] s);
  begin
    @(posedge core_clk_i) #1;
    rd_addr_i = {b, 19'h0F0F};
    #1;
    cmp(rd_src_o, s);
    cmp(rd_state_o, 4'h1 << s);
  end
  endtask
  task t_modes;
  begin
    see(4'hF, 2'h0);
    wr(4'h1, 8'h70);
    wr(4'h2, 8'h90);
    wr(4'h3, 8'h98);
    wr(4'h4, 8'h10);
    wr(4'h5, 8'h40);
    wr(4'h6, 8'hE8);
    wr(4'h7, 8'h20);
    wr(4'h8, 8'h80);
    wr(4'h9, 8'hBC);
    wr(4'hA, 8'h90);
    cmp(cmd_ignored_o, 8'h0);
    see(4'h1, 2'h1);
    see(4'h2, 2'h2);
    see(4'h3, 2'h3);
    see(4'h4, 2'h1);
    see(4'h5, 2'h1);
    see(4'h6, 2'h1);
    see(4'h7, 2'h1);
    see(4'h8, 2'h1);
    see(4'h9, 2'h1);
    see(4'hA, 2'h2);
    wr(4'h1, 8'h50);
    wr(4'h1, 8'hD0);
    wr(4'h1, 8'hCB);
    wr(4'h1, 8'hB0);
    wr(4'h2, 8'hFF);
    see(4'h1, 2'h1);
    see(4'h2, 2'h0);
    see(4'h0, 2'h0);
    $display("t_modes done");
  end
  endtask
  task t_busy;
  begin
    pec_active_i = 1'b1;
    wr(4'h3, 8'h20);
    cmp(cmd_ignored_o, 8'h1);
    wr(4'h3, 8'hD0);
    cmp(cmd_ignored_o, 8'h1);
    see(4'h3, 2'h3);
    wr(4'h4, 8'hFF);
    see(4'h4, 2'h0);
    wr(4'hC, 8'h70);
    see(4'hC, 2'h1);
    pec_active_i = 1'b0;
    illegal_state_i = 1'b1;
    wr(4'hD, 8'h70);
    illegal_state_i = 1'b0;
    see(4'hD, 2'h0);
    $display("t_busy done");
  end
  endtask
  // Reset in mid-run must put loaded banks back to array
  task t_reset;
  begin
    @(posedge core_clk_i) #1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    see(4'h1, 2'h0);
    see(4'h3, 2'h0);
    see(4'hC, 2'h0);
    wr(4'h5, 8'h98);
    see(4'h5, 2'h3);
    $display("t_reset done");
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    t_modes;
    t_busy;
    t_reset;
    close_out;
  end
  initial
  begin
    #20000;
    mismatches = mismatches + 1;
    close_out;
  end
endmodule
